// ===== logic/pee_pkg.sv
// Functional notes
// - Take simultaneous exceptions by priority: reset, dabort, fiq, irq, pabort, undef/trap.
// - Undefined and software trap never taken together; both lowest priority.
// - Data abort entry first, then fast interrupt taken at once.
// - Program counter jumps to the fixed vector of the taken exception.
// - Whole current status word copied to the target mode's saved status word.
// - Mode bits switch to target mode and its banked registers.
// - Normal-interrupt mask set on every exception entry.
// - Fast-interrupt mask set only for fast interrupt or reset, else kept.
// - Counter is fetch address; decode at counter-4, execute at counter-8.
// - Undefined and trap entry write counter-4 into the banked return link.
// - Interrupt taken at instruction end (fast interrupt also right after data abort entry), pin low and mask clear.
// - Interrupt entry writes counter-4 into the banked return link.
// - Illegal fetch tags instruction; prefetch abort raised when it reaches execute.
// - Prefetch abort link addresses the instruction after the aborted one.
// - Data abort entry writes counter-4 into the abort return link.
// - Flag-setting data op writing counter restores status from saved word in privileged modes only; in user mode it loads only the counter.
// - Load-multiple with restore qualifier copies saved word, privileged modes only.
// - Interrupt pins are active low and gated by their own mask bits.
package pee_pkg;
    localparam int unsigned PEE_W = 32;
    localparam logic [31:0] PEE_VEC_RESET = 32'h0000_0000;
    localparam logic [31:0] PEE_VEC_UNDEF = 32'h0000_0004;
    localparam logic [31:0] PEE_VEC_TRAP = 32'h0000_0008;
    localparam logic [31:0] PEE_VEC_PABT = 32'h0000_000C;
    localparam logic [31:0] PEE_VEC_DABT = 32'h0000_0010;
    localparam logic [31:0] PEE_VEC_RSVD = 32'h0000_0014;
    localparam logic [31:0] PEE_VEC_IRQ = 32'h0000_0018;
    localparam logic [31:0] PEE_VEC_FIQ = 32'h0000_001C;
    localparam logic [31:0] PEE_PC_STEP = 32'h0000_0004;
    localparam logic [31:0] PEE_LINK_OFS = 32'h0000_0004;
    localparam int unsigned PEE_F_BIT = 6;
    localparam int unsigned PEE_I_BIT = 7;
    localparam int unsigned PEE_MODE_W = 5;
    localparam logic [4:0] PEE_MODE_USER = 5'h10;
    localparam logic [4:0] PEE_MODE_FIQ = 5'h11;
    localparam logic [4:0] PEE_MODE_IRQ = 5'h12;
    localparam logic [4:0] PEE_MODE_SUPV = 5'h13;
    localparam logic [4:0] PEE_MODE_ABT = 5'h17;
    localparam logic [4:0] PEE_MODE_UND = 5'h1B;
    localparam logic [31:0] PEE_STATUS_RST = 32'h0000_00D3;
    localparam int unsigned PEE_ADDR_W = 3;
    localparam logic [2:0] PEE_REG_STATUS = 3'h0;
    localparam logic [2:0] PEE_REG_PC = 3'h1;
    localparam logic [2:0] PEE_REG_SAVED = 3'h2;
    localparam logic [2:0] PEE_REG_LINK = 3'h3;
    localparam logic [2:0] PEE_REG_LAST = 3'h4;
    localparam int unsigned PEE_BANKS = 5;

    typedef enum logic [2:0] {
        PEE_EXC_NONE, PEE_EXC_RESET, PEE_EXC_UNDEF, PEE_EXC_TRAP,
        PEE_EXC_PABT, PEE_EXC_DABT, PEE_EXC_IRQ, PEE_EXC_FIQ
    } pee_exc_t;

    typedef enum logic [2:0] {
        PEE_BK_FIQ, PEE_BK_IRQ, PEE_BK_SUPV, PEE_BK_ABT, PEE_BK_UND
    } pee_bank_t;

    function automatic logic [31:0] pee_vector(input pee_exc_t e);
        unique case (e)
            PEE_EXC_UNDEF: pee_vector = PEE_VEC_UNDEF;
            PEE_EXC_TRAP: pee_vector = PEE_VEC_TRAP;
            PEE_EXC_PABT: pee_vector = PEE_VEC_PABT;
            PEE_EXC_DABT: pee_vector = PEE_VEC_DABT;
            PEE_EXC_IRQ: pee_vector = PEE_VEC_IRQ;
            PEE_EXC_FIQ: pee_vector = PEE_VEC_FIQ;
            default: pee_vector = PEE_VEC_RESET;
        endcase
    endfunction

    function automatic logic [4:0] pee_target_mode(input pee_exc_t e);
        unique case (e)
            PEE_EXC_UNDEF: pee_target_mode = PEE_MODE_UND;
            PEE_EXC_PABT, PEE_EXC_DABT: pee_target_mode = PEE_MODE_ABT;
            PEE_EXC_IRQ: pee_target_mode = PEE_MODE_IRQ;
            PEE_EXC_FIQ: pee_target_mode = PEE_MODE_FIQ;
            default: pee_target_mode = PEE_MODE_SUPV;
        endcase
    endfunction

    function automatic pee_bank_t pee_bank_of(input logic [4:0] m);
        unique case (m)
            PEE_MODE_FIQ: pee_bank_of = PEE_BK_FIQ;
            PEE_MODE_IRQ: pee_bank_of = PEE_BK_IRQ;
            PEE_MODE_ABT: pee_bank_of = PEE_BK_ABT;
            PEE_MODE_UND: pee_bank_of = PEE_BK_UND;
            default: pee_bank_of = PEE_BK_SUPV;
        endcase
    endfunction
endpackage

// ===== logic/pee_exception_entry.sv
`timescale 1ns/1ps
module pee_exception_entry
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic irq_n_in,
    input wire logic fiq_n_in,
    input wire logic fetch_step_in,
    input wire logic fetch_abort_in,
    input wire logic instr_done_in,
    input wire logic undef_in,
    input wire logic trap_in,
    input wire logic data_abort_in,
    input wire logic restore_dp_in,
    input wire logic restore_ldm_in,
    input wire logic [31:0] new_pc_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic [31:0] pc_out,
    output logic [31:0] status_out,
    output logic taken_out,
    output pee_pkg::pee_exc_t taken_kind_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin synchronisers

    logic [2:0] irq_sync_q;
    logic [2:0] fiq_sync_q;
    logic irq_lvl_n_q;
    logic fiq_lvl_n_q;
    logic irq_lvl_n_d;
    logic fiq_lvl_n_d;

    always_comb
    begin
        irq_lvl_n_d = (irq_sync_q[1] == irq_sync_q[2]) ? irq_sync_q[2] : irq_lvl_n_q;
        fiq_lvl_n_d = (fiq_sync_q[1] == fiq_sync_q[2]) ? fiq_sync_q[2] : fiq_lvl_n_q;
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            irq_sync_q <= 3'h7;
            fiq_sync_q <= 3'h7;
            irq_lvl_n_q <= 1'b1;
            fiq_lvl_n_q <= 1'b1;
        end
        else
        begin
            irq_sync_q <= {irq_sync_q[1:0], irq_n_in};
            fiq_sync_q <= {fiq_sync_q[1:0], fiq_n_in};
            irq_lvl_n_q <= irq_lvl_n_d;
            fiq_lvl_n_q <= fiq_lvl_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration

    logic [31:0] pc_q;
    logic [31:0] status_q;
    logic dec_bad_q;
    logic exe_bad_q;
    logic rst_pend_q;
    logic chain_q;
    logic boundary;
    logic fiq_req;
    logic irq_req;
    pee_pkg::pee_exc_t sel;

    always_comb
    begin
        boundary = instr_done_in | chain_q;
        fiq_req = ~fiq_lvl_n_q & ~status_q[pee_pkg::PEE_F_BIT];
        irq_req = ~irq_lvl_n_q & ~status_q[pee_pkg::PEE_I_BIT];
        sel = pee_pkg::PEE_EXC_NONE;
        if (rst_pend_q)
            sel = pee_pkg::PEE_EXC_RESET;
        else if (instr_done_in && data_abort_in)
            sel = pee_pkg::PEE_EXC_DABT;
        else if (boundary && fiq_req)
            sel = pee_pkg::PEE_EXC_FIQ;
        else if (instr_done_in && irq_req)
            sel = pee_pkg::PEE_EXC_IRQ;
        else if (instr_done_in && exe_bad_q)
            sel = pee_pkg::PEE_EXC_PABT;
        else if (instr_done_in && undef_in)
            sel = pee_pkg::PEE_EXC_UNDEF;
        else if (instr_done_in && trap_in)
            sel = pee_pkg::PEE_EXC_TRAP;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status, counter and banked state

    logic [31:0] saved_q [pee_pkg::PEE_BANKS];
    logic [31:0] link_q [pee_pkg::PEE_BANKS];
    logic [31:0] pc_d;
    logic [31:0] status_d;
    logic dec_bad_d;
    logic exe_bad_d;
    logic chain_d;
    logic taken_d;
    logic bank_we;
    pee_pkg::pee_bank_t bank_idx;
    pee_pkg::pee_bank_t cur_bank;
    logic [31:0] link_val;
    logic privileged;
    logic [31:0] rdata_d;
    pee_pkg::pee_exc_t last_q;

    always_comb
    begin
        cur_bank = pee_pkg::pee_bank_of(status_q[pee_pkg::PEE_MODE_W-1:0]);
        privileged = status_q[pee_pkg::PEE_MODE_W-1:0] != pee_pkg::PEE_MODE_USER;
        pc_d = pc_q;
        status_d = status_q;
        dec_bad_d = dec_bad_q;
        exe_bad_d = exe_bad_q;
        chain_d = 1'b0;
        taken_d = 1'b0;
        bank_we = 1'b0;
        bank_idx = pee_pkg::pee_bank_of(pee_pkg::pee_target_mode(sel));
        link_val = pc_q - pee_pkg::PEE_LINK_OFS;
        if (reg_wr_in && reg_addr_in == pee_pkg::PEE_REG_STATUS)
            status_d = reg_wdata_in;
        if (fetch_step_in)
        begin
            pc_d = pc_q + pee_pkg::PEE_PC_STEP;
            dec_bad_d = fetch_abort_in;
            exe_bad_d = dec_bad_q;
        end
        if (sel != pee_pkg::PEE_EXC_NONE)
        begin
            bank_we = 1'b1;
            taken_d = 1'b1;
            chain_d = sel == pee_pkg::PEE_EXC_DABT;
            status_d = status_q;
            status_d[pee_pkg::PEE_MODE_W-1:0] = pee_pkg::pee_target_mode(sel);
            status_d[pee_pkg::PEE_I_BIT] = 1'b1;
            if (sel == pee_pkg::PEE_EXC_FIQ || sel == pee_pkg::PEE_EXC_RESET)
                status_d[pee_pkg::PEE_F_BIT] = 1'b1;
            pc_d = pee_pkg::pee_vector(sel);
            dec_bad_d = 1'b0;
            exe_bad_d = 1'b0;
        end
        else if (restore_dp_in || (restore_ldm_in && privileged))
        begin
            if (privileged)
                status_d = saved_q[cur_bank];
            pc_d = new_pc_in;
            dec_bad_d = 1'b0;
            exe_bad_d = 1'b0;
        end
        rdata_d = 32'h0000_0000;
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                pee_pkg::PEE_REG_STATUS: rdata_d = status_q;
                pee_pkg::PEE_REG_PC: rdata_d = pc_q;
                pee_pkg::PEE_REG_SAVED: rdata_d = saved_q[cur_bank];
                pee_pkg::PEE_REG_LINK: rdata_d = link_q[cur_bank];
                pee_pkg::PEE_REG_LAST: rdata_d = {29'h0000_0000, last_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pc_q <= pee_pkg::PEE_VEC_RESET;
            status_q <= pee_pkg::PEE_STATUS_RST;
            dec_bad_q <= 1'b0;
            exe_bad_q <= 1'b0;
            rst_pend_q <= 1'b1;
            chain_q <= 1'b0;
            taken_out <= 1'b0;
            last_q <= pee_pkg::PEE_EXC_NONE;
            reg_rdata_out <= 32'h0000_0000;
        end
        else
        begin
            pc_q <= pc_d;
            status_q <= status_d;
            dec_bad_q <= dec_bad_d;
            exe_bad_q <= exe_bad_d;
            rst_pend_q <= 1'b0;
            chain_q <= chain_d;
            taken_out <= taken_d;
            last_q <= taken_d ? sel : last_q;
            reg_rdata_out <= rdata_d;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (bank_we)
        begin
            saved_q[bank_idx] <= status_q;
            link_q[bank_idx] <= link_val;
        end
    end

    assign pc_out = pc_q;
    assign status_out = status_q;
    assign taken_kind_out = last_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    reset_first_a: assert property ((rst_pend_q) |=> (taken_out && last_q == pee_pkg::PEE_EXC_RESET
        && pc_q == pee_pkg::PEE_VEC_RESET))
        else $error("reset not taken first");
    dabt_over_fiq_a: assert property ((instr_done_in && data_abort_in && !rst_pend_q)
        |=> last_q == pee_pkg::PEE_EXC_DABT)
        else $error("data abort lost priority");
    dabt_chain_a: assert property ((taken_out && last_q == pee_pkg::PEE_EXC_DABT && fiq_req)
        |-> sel == pee_pkg::PEE_EXC_FIQ)
        else $error("fast interrupt not chained after data abort");
    vector_pc_a: assert property ((sel != pee_pkg::PEE_EXC_NONE)
        |=> pc_q == pee_pkg::pee_vector($past(sel)))
        else $error("counter not at vector");
    reserved_slot_a: assert property (taken_out |-> pc_q != pee_pkg::PEE_VEC_RSVD)
        else $error("reserved vector used");
    save_status_a: assert property ((sel != pee_pkg::PEE_EXC_NONE)
        |=> ##1 saved_q[$past(bank_idx, 2)] == $past(status_q, 2))
        else $error("status not saved");
    irq_mask_a: assert property (taken_out |-> status_q[pee_pkg::PEE_I_BIT])
        else $error("normal mask not set");
    fiq_mask_a: assert property ((sel == pee_pkg::PEE_EXC_IRQ || sel == pee_pkg::PEE_EXC_DABT)
        |=> status_q[pee_pkg::PEE_F_BIT] == $past(status_q[pee_pkg::PEE_F_BIT]))
        else $error("fast mask changed");
    link_value_a: assert property ((sel != pee_pkg::PEE_EXC_NONE)
        |=> ##1 link_q[$past(bank_idx, 2)] == $past(pc_q, 2) - pee_pkg::PEE_LINK_OFS)
        else $error("return link wrong");
    masked_irq_a: assert property ((status_q[pee_pkg::PEE_I_BIT] && !rst_pend_q)
        |-> sel != pee_pkg::PEE_EXC_IRQ)
        else $error("masked interrupt taken");
    mode_switch_a: assert property ((sel != pee_pkg::PEE_EXC_NONE)
        |=> status_q[pee_pkg::PEE_MODE_W-1:0] == pee_pkg::pee_target_mode($past(sel)))
        else $error("mode not switched");
    pabt_tag_a: assert property ((fetch_step_in && fetch_abort_in && sel == pee_pkg::PEE_EXC_NONE
        && !restore_dp_in && !restore_ldm_in) |=> dec_bad_q)
        else $error("bad fetch not tagged");

    irq_entry_c: cover property (taken_out && last_q == pee_pkg::PEE_EXC_IRQ);
    chain_c: cover property (chain_q && sel == pee_pkg::PEE_EXC_FIQ);
    pabt_c: cover property (taken_out && last_q == pee_pkg::PEE_EXC_PABT);
    restore_c: cover property (restore_ldm_in && privileged);

endmodule

// ===== testbench/pee_far_model.sv
`timescale 1ns/1ps
module pee_far_model
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic irq_req_in,
    input wire logic fiq_req_in,
    output logic irq_n_out,
    output logic fiq_n_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Request pins, active low, pulled high when idle
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            irq_n_out <= 1'b1;
            fiq_n_out <= 1'b1;
        end
        else
        begin
            irq_n_out <= ~irq_req_in;
            fiq_n_out <= ~fiq_req_in;
        end
    end
endmodule

// ===== testbench/pee_exception_entry_test.sv
`timescale 1ns/1ps
module pee_exception_entry_test;
    localparam logic [7:0] STEP = 8'h80;
    localparam logic [7:0] FAB = 8'h40;
    localparam logic [7:0] DONE = 8'h20;
    localparam logic [7:0] UND = 8'h10;
    localparam logic [7:0] TRP = 8'h08;
    localparam logic [7:0] DAB = 8'h04;
    localparam logic [7:0] RDP = 8'h02;
    localparam logic [7:0] RLM = 8'h01;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic irq_req = 1'b0;
    logic fiq_req = 1'b0;
    logic irq_n;
    logic fiq_n;
    logic [7:0] st = 8'h00;
    logic [31:0] new_pc = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [2:0] addr = 3'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic [31:0] pc;
    logic [31:0] status;
    logic taken;
    pee_pkg::pee_exc_t kind;
    logic [31:0] r;
    logic [31:0] m_pc;
    logic [31:0] m_st;
    int n_fail = 0;
    int checked = 0;

    always #20 ref_clk_in = ~ref_clk_in;

    pee_far_model far (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .irq_req_in(irq_req),
        .fiq_req_in(fiq_req), .irq_n_out(irq_n), .fiq_n_out(fiq_n));

    pee_exception_entry dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .irq_n_in(irq_n),
        .fiq_n_in(fiq_n), .fetch_step_in(st[7]), .fetch_abort_in(st[6]), .instr_done_in(st[5]),
        .undef_in(st[4]), .trap_in(st[3]), .data_abort_in(st[2]), .restore_dp_in(st[1]),
        .restore_ldm_in(st[0]), .new_pc_in(new_pc), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .pc_out(pc),
        .status_out(status), .taken_out(taken), .taken_kind_out(kind));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic test_done();
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_in);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk_in);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge ref_clk_in);
        rd_s <= 1'b0;
        #1 r = rdata;
    endtask

    task automatic go(input logic [7:0] v, input logic [31:0] npc);
        @(posedge ref_clk_in);
        st <= v;
        new_pc <= npc;
        @(posedge ref_clk_in);
        st <= 8'h00;
        #1;
    endtask

    task automatic step(input logic ab);
        go(ab ? (STEP | FAB) : STEP, 32'h0000_0000);
        m_pc = m_pc + 32'h0000_0004;
    endtask

    task automatic pins(input logic i, input logic f);
        irq_req <= i;
        fiq_req <= f;
        repeat (6) @(posedge ref_clk_in);
    endtask

    task automatic ent(input pee_pkg::pee_exc_t k, input logic [31:0] vec, input logic [4:0] md,
        input logic fs, input logic rdb);
        logic [31:0] es;
        int i;
        es = {m_st[31:8], 1'b1, fs | m_st[6], m_st[5], md};
        for (i = 0; i < 8 && taken !== 1'b1; i++)
        begin
            @(posedge ref_clk_in);
            #1;
        end
        if (i == 8)
        begin
            n_fail++;
            test_done();
        end
        chk({29'h0000_0000, kind}, {29'h0000_0000, k});
        chk(pc, vec);
        chk(status, es);
        if (rdb)
        begin
            rd(3'h2);
            chk(r, m_st);
            rd(3'h3);
            chk(r, m_pc - 32'h0000_0004);
        end
        m_st = es;
        m_pc = vec;
    endtask

    task automatic ret(input logic [7:0] v, input logic [31:0] npc, input logic [31:0] est);
        go(v, npc);
        chk(pc, npc);
        chk(status, est);
        m_pc = npc;
        m_st = est;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (4) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        m_pc = 32'h0000_0000;
        m_st = 32'h0000_00D3;
        #1;
        ent(pee_pkg::PEE_EXC_RESET, pee_pkg::PEE_VEC_RESET, pee_pkg::PEE_MODE_SUPV, 1'b1, 1'b0);
        rd(3'h2);
        chk(r, 32'h0000_00D3);
        wr(3'h0, 32'h0000_0010);
        rd(3'h0);
        chk(r, 32'h0000_0010);
        m_st = 32'h0000_0010;
        rd(3'h5);
        chk(r, 32'h0000_0000);
        wr(3'h1, 32'h0000_0055);
        repeat (3) step(1'b0);
        rd(3'h1);
        chk(r, m_pc);
        go(DONE | UND, 32'h0000_0000);
        ent(pee_pkg::PEE_EXC_UNDEF, pee_pkg::PEE_VEC_UNDEF, pee_pkg::PEE_MODE_UND, 1'b0, 1'b1);
        ret(RDP, 32'h0000_0100, 32'h0000_0010);
        go(DONE | TRP, 32'h0000_0000);
        ent(pee_pkg::PEE_EXC_TRAP, pee_pkg::PEE_VEC_TRAP, pee_pkg::PEE_MODE_SUPV, 1'b0, 1'b1);
        ret(RLM, 32'h0000_0200, 32'h0000_0010);
        go(RLM, 32'h0000_0300);
        chk(pc, m_pc);
        wr(3'h0, 32'h0000_0090);
        m_st = 32'h0000_0090;
        pins(1'b1, 1'b0);
        go(DONE, 32'h0000_0000);
        chk({31'h0000_0000, taken}, 32'h0000_0000);
        wr(3'h0, 32'h0000_0010);
        m_st = 32'h0000_0010;
        go(DONE, 32'h0000_0000);
        ent(pee_pkg::PEE_EXC_IRQ, pee_pkg::PEE_VEC_IRQ, pee_pkg::PEE_MODE_IRQ, 1'b0, 1'b1);
        ret(RDP, 32'h0000_0200, 32'h0000_0010);
        pins(1'b1, 1'b1);
        step(1'b1);
        step(1'b0);
        go(DONE | UND, 32'h0000_0000);
        ent(pee_pkg::PEE_EXC_FIQ, pee_pkg::PEE_VEC_FIQ, pee_pkg::PEE_MODE_FIQ, 1'b1, 1'b1);
        pins(1'b1, 1'b0);
        ret(RDP, 32'h0000_0200, 32'h0000_0010);
        go(DONE | UND, 32'h0000_0000);
        ent(pee_pkg::PEE_EXC_IRQ, pee_pkg::PEE_VEC_IRQ, pee_pkg::PEE_MODE_IRQ, 1'b0, 1'b1);
        pins(1'b0, 1'b0);
        ret(RDP, 32'h0000_0200, 32'h0000_0010);
        step(1'b1);
        go(DONE, 32'h0000_0000);
        chk({31'h0000_0000, taken}, 32'h0000_0000);
        step(1'b0);
        go(DONE | UND, 32'h0000_0000);
        ent(pee_pkg::PEE_EXC_PABT, pee_pkg::PEE_VEC_PABT, pee_pkg::PEE_MODE_ABT, 1'b0, 1'b1);
        ret(RDP, 32'h0000_0204 - 32'h0000_0004, 32'h0000_0010);
        pins(1'b0, 1'b1);
        go(DONE | DAB, 32'h0000_0000);
        ent(pee_pkg::PEE_EXC_DABT, pee_pkg::PEE_VEC_DABT, pee_pkg::PEE_MODE_ABT, 1'b0, 1'b0);
        @(posedge ref_clk_in);
        #1;
        ent(pee_pkg::PEE_EXC_FIQ, pee_pkg::PEE_VEC_FIQ, pee_pkg::PEE_MODE_FIQ, 1'b1, 1'b1);
        pins(1'b0, 1'b0);
        ret(RDP, 32'h0000_0500, 32'h0000_0097);
        ret(RLM, 32'h0000_0600, 32'h0000_0010);
        go(DONE | DAB, 32'h0000_0000);
        ent(pee_pkg::PEE_EXC_DABT, pee_pkg::PEE_VEC_DABT, pee_pkg::PEE_MODE_ABT, 1'b0, 1'b1);
        rd(3'h4);
        chk(r, {29'h0000_0000, pee_pkg::PEE_EXC_DABT});
        ret(RDP, 32'h0000_05FC - 32'h0000_0008, 32'h0000_0010);
        test_done();
    end
endmodule
